// ==== inc/bssp_pkg.sv ====
package bssp_pkg;

    // ==========================================================
    // Address map (word index; byte address is index times four)
    // ==========================================================
    localparam int          ADDR_W         = 18;
    localparam logic [15:0] IDX_BUF_FIRST  = 16'hff80;
    localparam logic [15:0] IDX_BUF_LAST   = 16'hff9f;
    localparam logic [15:0] IDX_CTRL       = 16'hffa8;
    localparam logic [15:0] IDX_STATUS     = 16'hffa9;
    localparam logic [15:0] IDX_START_PTR  = 16'hffaa;
    localparam logic [15:0] IDX_END_PTR    = 16'hffab;
    localparam logic [15:0] IDX_PIN_FUNC   = 16'hffac;
    localparam logic [15:0] IDX_PIN_OUT    = 16'hffad;
    localparam logic [15:0] IDX_IRQ_REQ    = 16'hffae;
    localparam logic [15:0] IDX_IRQ_EN     = 16'hffaf;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int BIT_DIR_TX      = 4;
    localparam int BIT_LAST_BIT    = 4;
    localparam int BIT_OVR         = 3;
    localparam int BIT_WT          = 2;
    localparam int BIT_GIT         = 1;
    localparam int BIT_START_BUSY  = 0;
    localparam int BIT_DRIVE_SEL   = 6;
    localparam int BIT_CS_SEL      = 5;
    localparam int BIT_SO_PIN_EN   = 6;
    localparam int BIT_SI_SEL      = 5;
    localparam int BIT_IRQ         = 0;

    // ==========================================================
    // Reset and fixed values
    // ==========================================================
    localparam logic [7:0]  CTRL_RST       = 8'he0;
    localparam logic [7:0]  STATUS_ONES    = 8'he0;
    localparam logic [7:0]  PIN_OUT_RST    = 8'h97;
    localparam logic [7:0]  PIN_OUT_ONES   = 8'h97;
    localparam logic [31:0] BUSY_READ_VAL  = 32'h0000_00ff;
    localparam logic [1:0]  CLK_SEL_EXT    = 2'b11;

    // ==========================================================
    // Timing counts in system clocks
    // ==========================================================
    localparam logic [2:0]  HALF_DIV2      = 3'h1;
    localparam logic [2:0]  HALF_DIV4      = 3'h2;
    localparam logic [2:0]  HALF_DIV8      = 3'h4;
    localparam logic [2:0]  GAP_ONE        = 3'h1;
    localparam logic [2:0]  GAP_TWO        = 3'h2;
    localparam logic [3:0]  GAP_EIGHT      = 4'h8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW  = 2'b01,
        ST_HIGH = 2'b10,
        ST_GAP  = 2'b11
    } seq_state_type;

    typedef struct packed {
        logic       dir_tx;
        logic [1:0] gap_len;
        logic [1:0] clk_sel;
    } ser_cfg_type;

endpackage : bssp_pkg

// ==== design/buffered_serial_unit.sv ====
// Operation
// R01: Data pin push-pull when drive select is 0, open-drain when 1.
// R02: Input-select 0 gives port; else serial input or chip-select by cs bit.
// R03: Chip-select output works only with internal clock in transmit mode.
// R04: 32-byte buffer; any contiguous part sent in one started operation.
// R05: Buffer at FF80-FF9F; first and last byte from low 5 pointer bits.
// R06: Writing start flag 1 starts; reads 1 while busy, clears at end.
// R07: Writing start flag 0 aborts and resets the engine only.
// R08: Buffer writes ignored while busy; buffer reads return FF.
// R09: Request flag set at completion and on buffer access while busy.
// R10: Overrun flag on excess data; access-conflict flag on busy buffer access.
// R11: Start above end runs to top, wraps to bottom, continues to end.
// R12: Three internal divided clocks or external; internal drives clock pin.
// R13: Bytes travel least significant bit first.
// R14: Data changes on falling clock edge, sampled on rising edge.
// R15: Internal transmit may hold clock high for a gap at boundaries.
// R16: Chip-select stays low during any gap.
// R17: After internal transmit no clock until restart; data keeps last bit.
// R18: External clock shifts only while busy; later pulses ignored.
// R19: Between transfers data pin follows the last-bit field.
// R20: Internal receive starts clocking as soon as start flag is set.
// R21: Software clears start, configures, loads data, then sets start.
// R22: Both causes share one request; enable bit gates the interrupt.
// R23: Gap field 00 none, 01 one, 10 two, 11 eight cycles.
// R24: Gaps every 16 bits when interval bit 0, every 8 when 1.
// R25: Receive needs serial-input function; chip-select corrupts data.
`timescale 1ns/1ps
`default_nettype none

module buffered_serial_unit
    import bssp_pkg::*;
(
    input  wire logic              I_SYS_CLK,
    input  wire logic              I_SYS_RST,
    input  wire logic              I_PSEL,
    input  wire logic              I_PENABLE,
    input  wire logic              I_PWRITE,
    input  wire logic [ADDR_W-1:0] I_PADDR,
    input  wire logic [31:0]       I_PWDATA,
    output logic      [31:0]       O_PRDATA,
    output logic                   O_PREADY,
    output logic                   O_PSLVERR,
    input  wire logic              I_SCK,
    output logic                   O_SCK,
    output logic                   O_SCK_OE_N,
    input  wire logic              I_SI_CS,
    output logic                   O_CS,
    output logic                   O_CS_OE_N,
    output logic                   O_SO,
    output logic                   O_SO_OE_N,
    output logic                   O_SERIAL_IRQ
);

    // ==========================================================
    // Functions
    // ==========================================================
    function automatic logic [2:0] half_count(input logic [1:0] sel);
        logic [2:0] r;
        r = HALF_DIV2;
        if (sel == 2'b01) begin
            r = HALF_DIV4;
        end else if (sel == 2'b10) begin
            r = HALF_DIV8;
        end
        return r;
    endfunction : half_count

    function automatic logic [2:0] gap_count(input logic [1:0] len);
        logic [2:0] r;
        r = GAP_ONE;
        if (len == 2'b10) begin
            r = GAP_TWO;
        end else if (len == 2'b11) begin
            r = 3'(GAP_EIGHT - 4'h1) + 3'h1;
        end
        return r;
    endfunction : gap_count

    // ==========================================================
    // Registers
    // ==========================================================
    logic [7:0]    buf_mem [32];
    ser_cfg_type   cfg_ff;
    logic          busy_ff, ovr_ff, wt_ff, git_ff, last_bit_ff;
    logic [4:0]    start_ptr_ff, end_ptr_ff, ptr_ff;
    logic          drive_sel_ff, cs_sel_ff, so_pin_en_ff, si_sel_ff;
    logic          irq_req_ff, irq_en_ff;
    logic [31:0]   prdata_ff;
    logic [2:0]    bit_ff, cnt_ff;
    logic [7:0]    shreg_ff;
    logic          so_ff, half_ff, gap_due_ff, ext_done_ff;
    seq_state_type st_ff, nxt_st;
    logic [2:0]    nxt_cnt;
    logic          sck_s1_ff, sck_s2_ff, sck_s3_ff, sck_filt_ff;
    logic          si_s1_ff, si_s2_ff, si_s3_ff, si_filt_ff;

    // ==========================================================
    // Bus decode
    // ==========================================================
    wire [15:0] idx        = I_PADDR[ADDR_W-1:2];
    wire        setup      = I_PSEL & ~I_PENABLE;
    wire        access     = I_PSEL & I_PENABLE;
    wire        is_buf     = (idx >= IDX_BUF_FIRST) && (idx <= IDX_BUF_LAST);
    wire [4:0]  buf_pos    = idx[4:0];
    wire        hit_ctrl   = idx == IDX_CTRL;
    wire        hit_stat   = idx == IDX_STATUS;
    wire        hit_sptr   = idx == IDX_START_PTR;
    wire        hit_eptr   = idx == IDX_END_PTR;
    wire        hit_pfunc  = idx == IDX_PIN_FUNC;
    wire        hit_pout   = idx == IDX_PIN_OUT;
    wire        hit_ireq   = idx == IDX_IRQ_REQ;
    wire        hit_ien    = idx == IDX_IRQ_EN;
    wire        mapped     = is_buf | hit_ctrl | hit_stat | hit_sptr | hit_eptr
                             | hit_pfunc | hit_pout | hit_ireq | hit_ien;
    wire        wr         = access & I_PWRITE & mapped;
    wire        wr_stat    = wr & hit_stat;
    wire        buf_wr     = wr & is_buf & ~busy_ff;                 // R08
    wire        conflict   = access & is_buf & busy_ff;              // R10
    wire        internal   = cfg_ff.clk_sel != CLK_SEL_EXT;
    wire        go         = wr_stat & I_PWDATA[BIT_START_BUSY] & ~busy_ff;   // R06
    wire        abort      = wr_stat & ~I_PWDATA[BIT_START_BUSY] & busy_ff;   // R07

    wire [7:0] stat_rd = STATUS_ONES | {3'h0, last_bit_ff, ovr_ff, wt_ff, git_ff, busy_ff};
    wire [7:0] ctrl_rd = CTRL_RST | {3'h0, cfg_ff};
    wire [7:0] pout_rd = PIN_OUT_ONES | {1'b0, drive_sel_ff, cs_sel_ff, 5'h0};
    wire [7:0] pfun_rd = {1'b0, so_pin_en_ff, si_sel_ff, 5'h0};
    wire [7:0] buf_rd  = busy_ff ? BUSY_READ_VAL[7:0] : buf_mem[buf_pos];   // R08
    wire [7:0] rd_byte = is_buf    ? buf_rd :
                         hit_ctrl  ? ctrl_rd :
                         hit_stat  ? stat_rd :
                         hit_sptr  ? {3'h0, start_ptr_ff} :
                         hit_eptr  ? {3'h0, end_ptr_ff} :
                         hit_pfunc ? pfun_rd :
                         hit_pout  ? pout_rd :
                         hit_ireq  ? {7'h0, irq_req_ff} :
                         hit_ien   ? {7'h0, irq_en_ff} : 8'h00;

    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = access & ~mapped;
    assign O_PRDATA  = prdata_ff;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            prdata_ff <= 32'h0;
        end else if (setup) begin
            prdata_ff <= {24'h0, rd_byte};
        end
    end

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    wire si_pin   = (si_sel_ff & ~cs_sel_ff) ? I_SI_CS : 1'b1;        // R02 R25
    wire sck_stab = sck_s2_ff == sck_s3_ff;
    wire si_stab  = si_s2_ff == si_s3_ff;
    wire si_now   = si_stab ? si_s3_ff : si_filt_ff;
    wire ext_rise = sck_stab & sck_s3_ff & ~sck_filt_ff;
    wire ext_fall = sck_stab & ~sck_s3_ff & sck_filt_ff;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            {sck_s1_ff, sck_s2_ff, sck_s3_ff, sck_filt_ff} <= 4'hf;
            {si_s1_ff, si_s2_ff, si_s3_ff, si_filt_ff} <= 4'hf;
        end else begin
            {sck_s1_ff, sck_s2_ff, sck_s3_ff} <= {I_SCK, sck_s1_ff, sck_s2_ff};
            {si_s1_ff, si_s2_ff, si_s3_ff} <= {si_pin, si_s1_ff, si_s2_ff};
            sck_filt_ff <= sck_stab ? sck_s3_ff : sck_filt_ff;
            si_filt_ff <= si_stab ? si_s3_ff : si_filt_ff;
        end
    end

    // ==========================================================
    // Internal clock generator
    // ==========================================================
    wire last_pos  = ptr_ff == end_ptr_ff;
    wire int_rise  = st_ff == ST_LOW && cnt_ff == 3'h1;
    wire rise_ev   = busy_ff & (internal ? int_rise : ext_rise);     // R14 R18
    wire fall_ev   = busy_ff & ~internal & ext_fall;                 // R18
    wire byte_end  = rise_ev & (bit_ff == 3'h7);
    wire done      = byte_end & last_pos;

    always_comb begin
        nxt_st  = st_ff;
        nxt_cnt = cnt_ff - 3'h1;
        unique case (st_ff)
            ST_IDLE: begin
                nxt_cnt = half_count(cfg_ff.clk_sel);
                if (go & internal) begin
                    nxt_st = ST_LOW;                                 // R20
                end
            end
            ST_LOW: begin
                if (cnt_ff == 3'h1) begin
                    nxt_st  = done ? ST_IDLE : ST_HIGH;              // R17
                    nxt_cnt = half_count(cfg_ff.clk_sel);
                end
            end
            ST_HIGH: begin
                if (cnt_ff == 3'h1) begin
                    nxt_st  = gap_due_ff ? ST_GAP : ST_LOW;          // R15
                    nxt_cnt = gap_due_ff ? gap_count(cfg_ff.gap_len)
                                         : half_count(cfg_ff.clk_sel);   // R23
                end
            end
            ST_GAP: begin
                if (cnt_ff == 3'h1) begin
                    nxt_st  = ST_LOW;
                    nxt_cnt = half_count(cfg_ff.clk_sel);
                end
            end
        endcase
        if (abort) begin
            nxt_st = ST_IDLE;                                        // R07
        end
    end

    wire int_fall = busy_ff & internal & nxt_st == ST_LOW & st_ff != ST_LOW;   // R14

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            st_ff  <= ST_IDLE;
            cnt_ff <= HALF_DIV2;
        end else begin
            st_ff  <= nxt_st;
            cnt_ff <= nxt_cnt;
        end
    end

    // ==========================================================
    // Shift engine
    // ==========================================================
    wire [7:0] rx_byte  = {si_now, shreg_ff[7:1]};                   // R13
    wire [4:0] next_ptr = ptr_ff + 5'h1;                             // R11
    wire       gap_now  = internal & cfg_ff.dir_tx & (cfg_ff.gap_len != 2'b00)
                          & (git_ff | half_ff);                      // R24

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            busy_ff <= 1'b0;
            ptr_ff <= 5'h0;
            bit_ff <= 3'h0;
            shreg_ff <= 8'h0;
            so_ff <= 1'b0;
            half_ff <= 1'b0;
            gap_due_ff <= 1'b0;
        end else if (go) begin
            busy_ff <= 1'b1;                                         // R06
            ptr_ff <= start_ptr_ff;                                  // R05
            bit_ff <= 3'h0;
            shreg_ff <= buf_mem[start_ptr_ff];                       // R04
            so_ff <= internal & cfg_ff.dir_tx ? buf_mem[start_ptr_ff][0] : last_bit_ff;
            half_ff <= 1'b0;
            gap_due_ff <= 1'b0;
        end else if (abort) begin
            busy_ff <= 1'b0;                                         // R07
            bit_ff <= 3'h0;
            gap_due_ff <= 1'b0;
        end else begin
            if ((int_fall | fall_ev) & cfg_ff.dir_tx) begin
                so_ff <= shreg_ff[0];                                // R14
            end
            if (rise_ev) begin
                bit_ff <= bit_ff + 3'h1;
                shreg_ff <= rx_byte;
                gap_due_ff <= 1'b0;
            end
            if (byte_end) begin
                busy_ff <= ~last_pos;                                // R06
                ptr_ff <= next_ptr;
                shreg_ff <= buf_mem[next_ptr];
                half_ff <= ~half_ff;
                gap_due_ff <= gap_now & ~last_pos;                   // R15
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (buf_wr) begin
            buf_mem[buf_pos] <= I_PWDATA[7:0];
        end else if (byte_end & ~cfg_ff.dir_tx) begin
            buf_mem[ptr_ff] <= rx_byte;
        end
    end

    // ==========================================================
    // Software registers
    // ==========================================================
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            cfg_ff <= ser_cfg_type'(CTRL_RST[4:0]);
            start_ptr_ff <= 5'h0;
            end_ptr_ff <= 5'h0;
            {so_pin_en_ff, si_sel_ff} <= 2'b00;
            {drive_sel_ff, cs_sel_ff} <= PIN_OUT_RST[6:5];
            irq_en_ff <= 1'b0;
            git_ff <= 1'b0;
        end else begin
            if (wr & hit_ctrl) begin
                cfg_ff <= ser_cfg_type'(I_PWDATA[4:0]);
            end
            if (wr & hit_sptr) begin
                start_ptr_ff <= I_PWDATA[4:0];
            end
            if (wr & hit_eptr) begin
                end_ptr_ff <= I_PWDATA[4:0];
            end
            if (wr & hit_pfunc) begin
                so_pin_en_ff <= I_PWDATA[BIT_SO_PIN_EN];
                si_sel_ff <= I_PWDATA[BIT_SI_SEL];
            end
            if (wr & hit_pout) begin
                drive_sel_ff <= I_PWDATA[BIT_DRIVE_SEL];
                cs_sel_ff <= I_PWDATA[BIT_CS_SEL];
            end
            if (wr & hit_ien) begin
                irq_en_ff <= I_PWDATA[BIT_IRQ];
            end
            if (wr_stat) begin
                git_ff <= I_PWDATA[BIT_GIT];
            end
        end
    end

    // Flags set by hardware; set wins over a clearing write
    wire ovr_set = ext_done_ff & ext_rise & ~internal;              // R10

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            ovr_ff <= 1'b0;
            wt_ff <= 1'b0;
            irq_req_ff <= 1'b0;
            last_bit_ff <= 1'b0;
            ext_done_ff <= 1'b0;
        end else begin
            ovr_ff <= ovr_set | (ovr_ff & ~wr_stat);                 // R10
            wt_ff <= conflict | (wt_ff & ~wr_stat);                  // R10
            irq_req_ff <= done | conflict
                          | (irq_req_ff & ~(wr & hit_ireq & ~I_PWDATA[BIT_IRQ]));   // R09 R22
            if (done & cfg_ff.dir_tx) begin
                last_bit_ff <= so_ff;                                // R17 R18
            end else if (wr_stat) begin
                last_bit_ff <= I_PWDATA[BIT_LAST_BIT];               // R19
            end
            ext_done_ff <= go ? 1'b0 : (ext_done_ff | (done & ~internal));   // R18
        end
    end

    // ==========================================================
    // Pin drive
    // ==========================================================
    wire so_level = busy_ff ? so_ff : last_bit_ff;                   // R19
    wire cs_fn    = si_sel_ff & cs_sel_ff;                           // R02

    assign O_SO         = so_level;
    assign O_SO_OE_N    = ~so_pin_en_ff | (drive_sel_ff & so_level);   // R01
    assign O_SCK        = ~(internal & st_ff == ST_LOW);             // R12
    assign O_SCK_OE_N   = ~internal;                                 // R12
    assign O_CS         = ~(busy_ff & internal & cfg_ff.dir_tx);     // R03 R16
    assign O_CS_OE_N    = ~cs_fn;                                    // R02
    assign O_SERIAL_IRQ = irq_req_ff & irq_en_ff;                    // R22

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);

    sequence gap_entry_s;
        st_ff == ST_HIGH ##1 st_ff == ST_GAP;
    endsequence

    busy_read_ff_a: assert property (setup & ~I_PWRITE & is_buf & busy_ff       // R08
        |=> O_PRDATA == BUSY_READ_VAL) else $error("busy buffer read not FF");
    done_clear_a: assert property (done |=> !busy_ff && irq_req_ff)             // R06
        else $error("completion did not clear busy");
    conflict_flag_a: assert property (conflict |=> wt_ff && irq_req_ff)         // R10
        else $error("conflict flags not set");
    open_drain_a: assert property (so_pin_en_ff && drive_sel_ff                 // R01
        |-> O_SO_OE_N == so_level) else $error("open drain drive wrong");
    cs_pin_a: assert property (!si_sel_ff |-> O_CS_OE_N)                         // R02
        else $error("cs driven in port mode");
    gap_hold_a: assert property (gap_entry_s |-> O_SCK && !O_CS)                 // R15
        else $error("clock or select wrong in gap");
    so_on_fall_a: assert property (internal && busy_ff && $past(busy_ff)         // R14
        && $changed(so_ff) |-> st_ff == ST_LOW && $past(st_ff) != ST_LOW)
        else $error("data changed off falling edge");
    idle_clock_a: assert property (!busy_ff && !go |=> O_SCK)                    // R17
        else $error("clock pulsed while idle");
    idle_so_a: assert property (!busy_ff |-> O_SO == last_bit_ff)                // R19
        else $error("idle data not last bit");
    irq_out_a: assert property (done && irq_en_ff && !wr |=> O_SERIAL_IRQ)       // R22
        else $error("interrupt not raised");

endmodule : buffered_serial_unit

`default_nettype wire

// ==== verif/serial_partner_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ========
// Far-side serial peer
module serial_partner_model (
    input  wire logic        i_sck,
    input  wire logic        i_so,
    input  wire logic [7:0]  i_tx_byte,
    output logic             o_si,
    output logic [31:0]      o_rx_word
);
    logic [2:0] cnt_ff = 3'h0;
    initial o_si = 1'b1;
    initial o_rx_word = 32'h0;
    // Drive on falling edge
    always @(negedge i_sck) begin
        o_si <= i_tx_byte[cnt_ff];
        cnt_ff <= cnt_ff + 3'h1;
    end
    // Capture on rising edge
    always @(posedge i_sck) begin
        o_rx_word <= {i_so, o_rx_word[31:1]};
    end
endmodule : serial_partner_model
`default_nettype wire

// ==== verif/buffered_serial_unit_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module buffered_serial_unit_tb_top;
    import bssp_pkg::*;
    logic              clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd, rx_word;
    logic              sck, sck_oe_n, cs, cs_oe_n, so, so_oe_n, irq, si_pin, so_pin, part_si;
    logic              ext_sck, sck_pin;
    int                failures, samples_checked, cycles, cs_low, cs_base;
    // ========
    // Pins
    assign so_pin = so_oe_n ? 1'b1 : so;
    assign si_pin = cs_oe_n ? part_si : cs;
    assign sck_pin = sck_oe_n ? ext_sck : sck;
    buffered_serial_unit buffered_serial_unit_inst (
        .I_SYS_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SCK(ext_sck), .O_SCK(sck),
        .O_SCK_OE_N(sck_oe_n), .I_SI_CS(si_pin), .O_CS(cs), .O_CS_OE_N(cs_oe_n),
        .O_SO(so), .O_SO_OE_N(so_oe_n), .O_SERIAL_IRQ(irq));
    serial_partner_model serial_partner_model_inst (
        .i_sck(sck_pin), .i_so(so_pin), .i_tx_byte(8'ha5), .o_si(part_si), .o_rx_word(rx_word));
    always #2 clk = ~clk;
    // ========
    // Tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic xfer(input logic [15:0] idx, input logic wr, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : xfer
    task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp, input string name);
        xfer(idx, 1'b0, 8'h00);
        check(name, rd, {24'h0, exp});
    endtask : rdchk
    task automatic wait_idle;
        rd = 32'h1;
        while (rd[0] !== 1'b0) xfer(IDX_STATUS, 1'b0, 8'h00);
    endtask : wait_idle
    task automatic results;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    always @(posedge clk) begin
        cycles++;
        if (cs === 1'b0) begin
            cs_low++;
        end
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end
    // ========
    // Tests
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        ext_sck = 1'b1;
        failures = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdchk(IDX_CTRL, CTRL_RST, "ctrl");
        rdchk(IDX_STATUS, 8'he0, "status");
        rdchk(IDX_PIN_OUT, PIN_OUT_RST, "pin_out");
        xfer(16'hff00, 1'b0, 8'h00);
        check("pslverr", {31'h0, err}, 32'h1);
        xfer(IDX_STATUS, 1'b1, 8'h00);
        xfer(IDX_PIN_FUNC, 1'b1, 8'h60);
        xfer(IDX_PIN_OUT, 1'b1, 8'h20);
        xfer(IDX_BUF_FIRST + 16'd30, 1'b1, 8'h3c);
        xfer(IDX_BUF_LAST, 1'b1, 8'h81);
        xfer(IDX_BUF_FIRST, 1'b1, 8'h5a);
        xfer(IDX_START_PTR, 1'b1, 8'hfe);
        xfer(IDX_END_PTR, 1'b1, 8'he0);
        xfer(IDX_CTRL, 1'b1, 8'h10);
        xfer(IDX_IRQ_EN, 1'b1, 8'h01);
        xfer(IDX_STATUS, 1'b1, 8'h01);
        check("cs_pin", {30'h0, cs_oe_n, cs}, 32'h0);
        check("sck_oe_n", {31'h0, sck_oe_n}, 32'h0);
        rdchk(IDX_BUF_FIRST, 8'hff, "busy_rd");
        xfer(IDX_BUF_LAST, 1'b1, 8'h00);
        rdchk(IDX_STATUS, 8'he5, "st_busy");
        wait_idle();
        check("tx_bits", {8'h0, rx_word[31:8]}, 32'h005a813c);
        check("irq", {31'h0, irq}, 32'h1);
        rdchk(IDX_STATUS, 8'he4, "st_done");
        check("so_last", {31'h0, so_pin}, 32'h0);
        check("sck_idle", {31'h0, sck}, 32'h1);
        rdchk(IDX_BUF_LAST, 8'h81, "buf_kept");
        xfer(IDX_IRQ_REQ, 1'b1, 8'h00);
        check("irq_clr", {31'h0, irq}, 32'h0);
        xfer(IDX_STATUS, 1'b1, 8'h10);
        check("so_idle", {31'h0, so_pin}, 32'h1);
        rdchk(IDX_STATUS, 8'hf0, "st_clr");
        xfer(IDX_PIN_OUT, 1'b1, 8'h60);
        check("so_od", {31'h0, so_oe_n}, 32'h1);
        xfer(IDX_PIN_OUT, 1'b1, 8'h00);
        xfer(IDX_CTRL, 1'b1, 8'h02);
        xfer(IDX_START_PTR, 1'b1, 8'h05);
        xfer(IDX_END_PTR, 1'b1, 8'h05);
        xfer(IDX_STATUS, 1'b1, 8'h01);
        wait_idle();
        rdchk(IDX_BUF_FIRST + 16'd5, 8'ha5, "rx_byte");
        xfer(IDX_CTRL, 1'b1, 8'h1c);
        xfer(IDX_START_PTR, 1'b1, 8'h1e);
        xfer(IDX_END_PTR, 1'b1, 8'h1f);
        cs_base = cs_low;
        xfer(IDX_STATUS, 1'b1, 8'h03);
        wait_idle();
        check("gap_cycles", cs_low - cs_base, 32'd39);
        check("gap_bits", {16'h0, rx_word[31:16]}, 32'h0000813c);
        xfer(IDX_CTRL, 1'b1, 8'h03);
        xfer(IDX_START_PTR, 1'b1, 8'h06);
        xfer(IDX_END_PTR, 1'b1, 8'h06);
        xfer(IDX_STATUS, 1'b1, 8'h01);
        check("sck_in", {31'h0, sck_oe_n}, 32'h1);
        repeat (18) begin
            repeat (8) @(posedge clk);
            ext_sck <= ~ext_sck;
        end
        repeat (8) @(posedge clk);
        rdchk(IDX_STATUS, 8'he8, "ovr");
        rdchk(IDX_BUF_FIRST + 16'd6, 8'ha5, "ext_rx");
        xfer(IDX_CTRL, 1'b1, 8'h10);
        xfer(IDX_STATUS, 1'b1, 8'h01);
        xfer(IDX_STATUS, 1'b1, 8'h00);
        rdchk(IDX_STATUS, 8'he0, "abort");
        repeat (8) @(posedge clk);
        check("sck_stop", {31'h0, sck}, 32'h1);
        rdchk(IDX_CTRL, 8'hf0, "ctrl_kept");
        results();
    end
endmodule : buffered_serial_unit_tb_top
`default_nettype wire
